//--- fault_status_pkg.sv
// Constants and carrier types for the channel fault status register pair.
// Assumes a single 100 MHz core clock and a byte-wide register port.
package fault_status_pkg;
    localparam int NUM_CH = 4;
    localparam logic [7:0] ADDR_FAULT_SUMMARY = 8'h30;
    localparam logic [7:0] ADDR_OFFSTATE_FAULT = 8'h31;
    localparam logic [7:0] CMD_SOFT_RESET = 8'hFF;
    localparam logic [3:0] STATUS_RESET = 4'h0;
    localparam logic [3:0] RESERVED_BITS = 4'h0;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // Off-state diagnostic delay, in microseconds, and its cycle count
    localparam int CLK_MHZ = 100;
    localparam int DIAG_DELAY_US = 50;
    localparam int DIAG_DELAY_CYC = DIAG_DELAY_US * CLK_MHZ;
    localparam int CNT_W = 16;

    typedef struct packed {
        logic [3:0] drain_source_overload;
        logic [3:0] power_limit_flag;
        logic [3:0] overtemperature_flag;
        logic [3:0] output_above_threshold;
    } channel_flags_t;

    typedef struct packed {
        logic rd;
        logic clr;
        logic [7:0] addr;
    } reg_access_t;
endpackage

//--- offstate_delay_timer.sv
// Per-channel timer counting the off-state diagnostic delay after turn-off.
// Assumes channel_on is synchronous to the core clock.
`timescale 1ns/1ps
module offstate_delay_timer #(
    parameter int DELAY_CYC = fault_status_pkg::DIAG_DELAY_CYC
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic channel_on_in,
    output logic expired_out
);
    logic [fault_status_pkg::CNT_W-1:0] cnt_q;
    logic [fault_status_pkg::CNT_W-1:0] cnt_d;
    localparam logic [fault_status_pkg::CNT_W-1:0] LIMIT = DELAY_CYC[fault_status_pkg::CNT_W-1:0];
    localparam logic [fault_status_pkg::CNT_W-1:0] ONE = 16'h0001;

    wire done = (cnt_q == LIMIT);
    assign cnt_d = channel_on_in ? '0 : (done ? cnt_q : cnt_q + ONE);
    assign expired_out = done & ~channel_on_in;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            cnt_q <= '0;
        end else if (ce_in) begin
            cnt_q <= cnt_d;
        end
    end
endmodule

//--- channel_fault_status_regs.sv
// Fault summary and off-state fault status registers for four channels.
// Assumes fault flags and channel states come from core logic on mclk_in;
// output voltage comparator inputs are asynchronous and are synchronised here.
//
// Contract
// - Summary bit per channel is OR of overload, power-limit, overtemperature.
// - Overload flag excluded from summary when its mask is active.
// - Summary bit 1 means channel failure, 0 means none.
// - Summary bit refreshes while channel on, holds while off.
// - Summary never set under latch-off configuration or from masked overload.
// - Read-and-clear of summary register clears held bits.
// - Off-state bit set after diagnostic delay if output above threshold.
// - Off-state bit refreshes while channel off, holds while on.
// - Read-and-clear of off-state register clears held bits.
// - Off-state bit 1 means open load or stuck to supply.
// - Pull-up enable per channel drives internal pull-up current source.
// - Software reset command clears status registers and pull-up enables.
`timescale 1ns/1ps
module channel_fault_status_regs (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [3:0] channel_on_in,
    input wire logic [3:0] latch_off_cfg_in,
    input wire logic overload_mask_in,
    input wire logic [3:0] drain_source_overload_in,
    input wire logic [3:0] power_limit_flag_in,
    input wire logic [3:0] overtemperature_flag_in,
    input wire logic [3:0] openload_threshold_in,
    input wire logic cmd_valid_in,
    input wire logic [7:0] cmd_byte_in,
    input wire logic pullup_wr_in,
    input wire logic [3:0] pullup_wdata_in,
    input wire logic reg_rd_in,
    input wire logic reg_clr_in,
    input wire logic [7:0] reg_addr_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    output logic [3:0] pullup_enable_control_out,
    output logic [3:0] channel_fault_summary_out,
    output logic [3:0] offstate_fault_status_out
);
    fault_status_pkg::channel_flags_t flags;
    fault_status_pkg::reg_access_t acc;

    logic [3:0] thr_meta_q;
    logic [3:0] thr_sync_q;
    logic [3:0] summary_q;
    logic [3:0] summary_d;
    logic [3:0] offstate_q;
    logic [3:0] offstate_d;
    logic [3:0] pullup_q;
    logic [3:0] pullup_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic rvalid_q;
    logic [3:0] delay_done;

    // One driver per carrier: member-wise continuous assigns are refused by some tools
    assign flags = '{
        drain_source_overload: drain_source_overload_in,
        power_limit_flag: power_limit_flag_in,
        overtemperature_flag: overtemperature_flag_in,
        output_above_threshold: thr_sync_q
    };
    assign acc = '{
        rd: reg_rd_in,
        clr: reg_clr_in,
        addr: reg_addr_in
    };

    function automatic logic [7:0] pad_status(input logic [3:0] bits);
        pad_status = {fault_status_pkg::RESERVED_BITS, bits};
    endfunction

    function automatic logic [3:0] rc_update(
        input logic [3:0] held,
        input logic [3:0] live,
        input logic [3:0] refresh,
        input logic clear
    );
        logic [3:0] kept;
        kept = clear ? fault_status_pkg::STATUS_RESET : held;
        // Refreshing channels follow live flags; live set beats clear
        rc_update = (refresh & live) | (~refresh & kept);
    endfunction

    genvar ch;
    generate
        for (ch = 0; ch < fault_status_pkg::NUM_CH; ch = ch + 1) begin : g_timer
            offstate_delay_timer #(
                .DELAY_CYC(fault_status_pkg::DIAG_DELAY_CYC)
            ) u_timer (
                .mclk_in(mclk_in),
                .rst_in(rst_in),
                .ce_in(ce_in),
                .channel_on_in(channel_on_in[ch]),
                .expired_out(delay_done[ch])
            );
        end
    endgenerate

    wire soft_reset = cmd_valid_in & (cmd_byte_in == fault_status_pkg::CMD_SOFT_RESET);
    wire sel_summary = (acc.addr == fault_status_pkg::ADDR_FAULT_SUMMARY);
    wire sel_offstate = (acc.addr == fault_status_pkg::ADDR_OFFSTATE_FAULT);
    wire clr_summary = acc.rd & acc.clr & sel_summary;
    wire clr_offstate = acc.rd & acc.clr & sel_offstate;

    wire [3:0] ovl_term = flags.drain_source_overload & {4{~overload_mask_in}};
    wire [3:0] summary_live = (ovl_term | flags.power_limit_flag | flags.overtemperature_flag)
        & ~latch_off_cfg_in;
    // Held bit refreshed only while on; a 1 reports a channel failure
    wire [3:0] summary_next = rc_update(summary_q, summary_live, channel_on_in,
        clr_summary);

    // Threshold compare already reflects pull-up: with it, open load also reads high
    wire [3:0] offstate_live = flags.output_above_threshold & delay_done;
    // Off channels refresh; before the delay ends the live term is zero
    wire [3:0] offstate_next = rc_update(offstate_q, offstate_live, ~channel_on_in,
        clr_offstate);

    wire [7:0] read_mux = sel_summary ? pad_status(summary_q) :
        sel_offstate ? pad_status(offstate_q) : fault_status_pkg::READ_ZERO;

    assign summary_d = soft_reset ? fault_status_pkg::STATUS_RESET : summary_next;
    assign offstate_d = soft_reset ? fault_status_pkg::STATUS_RESET : offstate_next;
    assign pullup_d = soft_reset ? fault_status_pkg::STATUS_RESET :
        (pullup_wr_in ? pullup_wdata_in : pullup_q);
    assign rdata_d = acc.rd ? read_mux : rdata_q;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            thr_meta_q <= fault_status_pkg::STATUS_RESET;
            thr_sync_q <= fault_status_pkg::STATUS_RESET;
        end else if (ce_in) begin
            thr_meta_q <= openload_threshold_in;
            thr_sync_q <= thr_meta_q;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            summary_q <= fault_status_pkg::STATUS_RESET;
            offstate_q <= fault_status_pkg::STATUS_RESET;
            pullup_q <= fault_status_pkg::STATUS_RESET;
        end else if (ce_in) begin
            summary_q <= summary_d;
            offstate_q <= offstate_d;
            pullup_q <= pullup_d;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rdata_q <= fault_status_pkg::READ_ZERO;
            rvalid_q <= 1'b0;
        end else if (ce_in) begin
            rdata_q <= rdata_d;
            rvalid_q <= acc.rd;
        end
    end

    assign reg_rdata_out = rdata_q;
    assign reg_rvalid_out = rvalid_q;
    assign pullup_enable_control_out = pullup_q;
    assign channel_fault_summary_out = summary_q;
    assign offstate_fault_status_out = offstate_q;
endmodule

//--- fault_status_asserts.sv
// Checker for the fault status register pair, bound onto its ports.
// Assumes one clock domain and a synchronous reset.
`timescale 1ns/1ps
module fault_status_asserts (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic overload_mask_in,
    input wire logic cmd_valid_in,
    input wire logic pullup_wr_in,
    input wire logic reg_rd_in,
    input wire logic reg_clr_in,
    input wire logic reg_rvalid_out,
    input wire logic [3:0] channel_on_in,
    input wire logic [3:0] latch_off_cfg_in,
    input wire logic [3:0] drain_source_overload_in,
    input wire logic [3:0] power_limit_flag_in,
    input wire logic [3:0] overtemperature_flag_in,
    input wire logic [3:0] pullup_wdata_in,
    input wire logic [3:0] pullup_enable_control_out,
    input wire logic [3:0] channel_fault_summary_out,
    input wire logic [3:0] offstate_fault_status_out,
    input wire logic [7:0] cmd_byte_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_rdata_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    wire logic sr = ce_in && cmd_valid_in && cmd_byte_in == fault_status_pkg::CMD_SOFT_RESET;
    wire logic rc = ce_in && reg_rd_in && reg_clr_in && !sr;
    wire logic rc0 = rc && reg_addr_in == fault_status_pkg::ADDR_FAULT_SUMMARY;
    wire logic rc1 = rc && reg_addr_in == fault_status_pkg::ADDR_OFFSTATE_FAULT;
    wire logic [3:0] on = channel_on_in;
    wire logic [3:0] sm = channel_fault_summary_out;
    wire logic [3:0] os = offstate_fault_status_out;
    wire logic [3:0] lv = (drain_source_overload_in & ~{4{overload_mask_in}}
        | power_limit_flag_in | overtemperature_flag_in) & ~latch_off_cfg_in;
    wire logic [7:0] rv = rc0 || reg_addr_in == fault_status_pkg::ADDR_FAULT_SUMMARY ? {4'h0, sm}
        : reg_addr_in == fault_status_pkg::ADDR_OFFSTATE_FAULT ? {4'h0, os} : 8'h00;
    a_summary_live: assert property (
        ce_in && !sr |=> ((sm ^ $past(lv)) & $past(on)) == 0)
        else $error("summary differs from live flags");
    a_summary_hold: assert property (
        ce_in && !sr && !rc0 |=> ((sm ^ $past(sm)) & ~$past(on)) == 0)
        else $error("summary changed while off");
    a_summary_clear: assert property (rc0 |=> (sm & ~$past(on)) == 0)
        else $error("summary not cleared");
    a_offstate_hold: assert property (
        ce_in && !sr && !rc1 |=> ((os ^ $past(os)) & $past(on)) == 0)
        else $error("off-state bit changed while on");
    a_offstate_clear: assert property (rc1 |=> (os & $past(on)) == 0)
        else $error("off-state bit not cleared");
    a_offstate_delay: assert property ((os & ~$past(os) & ($past(on) | $past(on, 2))) == 0)
        else $error("off-state bit set without delay");
    a_read_data: assert property (
        ce_in && reg_rd_in |=> reg_rvalid_out && reg_rdata_out == $past(rv))
        else $error("read data wrong");
    a_soft_reset: assert property (
        sr |=> sm == 0 && os == 0 && pullup_enable_control_out == 0)
        else $error("soft reset left state");
    a_pullup_write: assert property (
        ce_in && pullup_wr_in && !sr |=> pullup_enable_control_out == $past(pullup_wdata_in))
        else $error("pull-up enables not written");
    // Clock enable low freezes every held register
    a_freeze_hold: assert property (
        !ce_in |=> sm == $past(sm) && os == $past(os)
            && pullup_enable_control_out == $past(pullup_enable_control_out))
        else $error("state moved while clock enable low");
endmodule

//--- host_model.sv
// Host side of the register port: one byte access per call.
// Assumes the answer comes one cycle after the request is taken.
`timescale 1ns/1ps
module host_model (
    input wire logic mclk_in,
    input wire logic [7:0] reg_rdata_in,
    input wire logic reg_rvalid_in,
    output fault_status_pkg::reg_access_t acc_out
);
    initial acc_out = '0;
    task automatic access(input logic clr, input logic [7:0] addr, output logic [7:0] data);
        @(posedge mclk_in);
        acc_out <= '{rd: 1'b1, clr: clr, addr: addr};
        @(posedge mclk_in);
        acc_out <= '0;
        #1;
        data = reg_rvalid_in ? reg_rdata_in : 8'hXX;
    endtask
endmodule

//--- testbench.sv
// Self-checking bench for the fault status register pair.
// Assumes the package default off-state delay.
`timescale 1ns/1ps
bind channel_fault_status_regs fault_status_asserts u_chk (.*);
module testbench;
    logic clk = 0, rst = 1, ce = 1, mk = 0, cv = 0, pw = 0, rval;
    logic [3:0] on = 0, lt = 0, ds = 0, pl = 0, ot = 0, th = 0, pd = 0, pu, sm, os, e;
    logic [7:0] cb = 0, rdat, d;
    fault_status_pkg::reg_access_t acc;
    int num_errors = 0, n_tests = 0, seed = 32'h705A5E8C;
    initial forever #5 clk = ~clk;
    host_model host (.mclk_in(clk), .reg_rdata_in(rdat), .reg_rvalid_in(rval), .acc_out(acc));
    channel_fault_status_regs DUT (.mclk_in(clk), .rst_in(rst), .ce_in(ce), .channel_on_in(on),
        .latch_off_cfg_in(lt), .overload_mask_in(mk), .drain_source_overload_in(ds),
        .power_limit_flag_in(pl), .overtemperature_flag_in(ot), .openload_threshold_in(th),
        .cmd_valid_in(cv), .cmd_byte_in(cb), .pullup_wr_in(pw), .pullup_wdata_in(pd),
        .reg_rd_in(acc.rd), .reg_clr_in(acc.clr), .reg_addr_in(acc.addr), .reg_rdata_out(rdat),
        .reg_rvalid_out(rval), .pullup_enable_control_out(pu), .channel_fault_summary_out(sm),
        .offstate_fault_status_out(os));
    task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
        n_tests++;
        if (g !== x) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    function automatic logic [3:0] live(input logic [3:0] a, b, c, l, input logic m);
        return ((a & ~{4{m}}) | b | c) & ~l;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 0;
        host.access(0, fault_status_pkg::ADDR_FAULT_SUMMARY, d);
        chk("reset read", 8'h00, d);
        host.access(0, 8'h55, d);
        chk("unmapped", 8'h00, d);
        repeat (20) begin
            @(posedge clk);
            on <= 4'hF;
            {ds, pl, ot, lt} <= 16'($random(seed));
            mk <= 1'($random(seed));
            tick(2);
            e = live(ds, pl, ot, lt, mk);
            chk("live", {4'h0, e}, {4'h0, sm});
            @(posedge clk);
            on <= 4'h0;
            {ds, pl, ot} <= ~{ds, pl, ot};
            tick(2);
            chk("held", {4'h0, e}, {4'h0, sm});
            host.access(1, fault_status_pkg::ADDR_FAULT_SUMMARY, d);
            chk("rc data", {4'h0, e}, d);
            chk("cleared", 8'h00, {4'h0, sm});
        end
        @(posedge clk);
        on <= 4'hF;
        tick(3);
        @(posedge clk);
        on <= 4'h0;
        th <= 4'hA;
        tick(fault_status_pkg::DIAG_DELAY_CYC - 4);
        chk("off early", 8'h00, {4'h0, os});
        tick(12);
        chk("off set", 8'h0A, {4'h0, os});
        @(posedge clk);
        on <= 4'hF;
        th <= 4'h5;
        lt <= 4'h0;
        tick(4);
        chk("off held", 8'h0A, {4'h0, os});
        host.access(1, fault_status_pkg::ADDR_OFFSTATE_FAULT, d);
        chk("off rc", 8'h0A, d);
        chk("off clr", 8'h00, {4'h0, os});
        @(posedge clk);
        pw <= 1;
        // Never all zero, so the soft reset check can see a change
        pd <= 4'($random(seed)) | 4'h1;
        pl <= 4'hF;
        @(posedge clk);
        pw <= 0;
        on <= 4'h0;
        tick(1);
        chk("pullup", {4'hF, pd}, {sm, pu});
        @(posedge clk);
        cv <= 1;
        cb <= fault_status_pkg::CMD_SOFT_RESET;
        @(posedge clk);
        cv <= 0;
        tick(1);
        chk("soft reset", 8'h00, {sm, pu});
        // Clock enable low: turning channels on must not refresh the summary
        @(posedge clk);
        on <= 4'hF;
        ce <= 0;
        tick(3);
        chk("frozen", 8'h00, {sm, os});
        @(posedge clk);
        ce <= 1;
        tick(2);
        chk("unfrozen", 8'h0F, {4'h0, sm});
        report_and_stop();
    end
    initial begin
        #200000;
        num_errors++;
        report_and_stop();
    end
endmodule
